// file: rtl/dtw_map.vh
// Register map, field positions, reset values and timing counts of the dual timer
`ifndef DTW_MAP_VH
`define DTW_MAP_VH
`define DTW_OFF_STAT 8'h00
`define DTW_OFF_LOAD0 8'h10
`define DTW_OFF_VAL0 8'h14
`define DTW_OFF_CTL0 8'h18
`define DTW_OFF_LOAD1 8'h20
`define DTW_OFF_VAL1 8'h24
`define DTW_OFF_CTL1 8'h28
`define DTW_OFF_RSTCAUSE 8'h30
`define DTW_OFF_PINFN 8'h34
`define DTW_STAT_INT0 0
`define DTW_STAT_INT1 1
`define DTW_STAT_RST0 4
`define DTW_STAT_RST1 5
`define DTW_CTL_EN 7
`define DTW_CTL_WDSRC 6
`define DTW_CTL_MODE_HI 5
`define DTW_CTL_MODE_LO 4
`define DTW_CTL_TEST 15
`define DTW_RSTCAUSE_WD 1
`define DTW_MODE_FREE 2'h0
`define DTW_MODE_PERIODIC 2'h1
`define DTW_MODE_TIMEOUT 2'h2
`define DTW_MODE_WATCHDOG 2'h3
`define DTW_PINFN_WDOUT 2'h1
`define DTW_PINFN_RESET 2'h2
`define DTW_LOAD_RESET 16'h0000
`define DTW_COUNT_RESET 16'hFFFF
`define DTW_FREE_RELOAD 16'hFFFF
`define DTW_WDPULSE_CYC 2'h3
`endif

// file: rtl/dtw_channel.v
// One 16-bit down-counting timer channel with its own pre-scaler
`timescale 1ns/1ns
`include "dtw_map.vh"
module dtw_channel #(
  parameter WIDTH = 16,
  parameter PS_W = 4
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // Control from registers
  input wire enable,
  input wire [1:0] mode,
  input wire [PS_W-1:0] prescale,
  input wire [WIDTH-1:0] load_value,
  input wire load_wr,
  input wire restart,
  // State out
  output reg [WIDTH-1:0] count_r,
  output wire expire,
  output wire clr_enable
);
  // Pre-scale divider, counts only while the channel is running
  reg [15:0] div_r;
  wire [15:0] div_nxt;
  // Tick selects divided clock: code n>0 divides by 2^(n+1)
  reg tick;
  wire [4:0] sh;
  wire running;
  wire zero_disables;

  assign sh = {1'b0, prescale} + 5'h01;
  assign div_nxt = div_r + 16'h0001;
  // Zero load halts every mode but free-running
  assign zero_disables = (mode != `DTW_MODE_FREE) && (load_value == 16'h0000);
  assign running = enable && !zero_disables;

  // Tick decode
  always @* begin
    if (prescale == {PS_W{1'b0}}) begin
      tick = 1'b1;
    end else if (sh >= 5'h10) begin
      tick = (div_r == 16'hFFFF);
    end else begin
      tick = ((div_r & ((16'h0001 << sh) - 16'h0001)) == ((16'h0001 << sh) - 16'h0001));
    end
  end

  // Expiry when count steps to zero on a tick
  assign expire = running && tick && (count_r == 16'h0001);
  // Time-out mode self-disables at zero; timer 0 maps watchdog code to time-out
  assign clr_enable = expire && (mode == `DTW_MODE_TIMEOUT);

  // Divider runs while the channel is running; cleared otherwise for a clean first period
  always @(posedge clk_sys) begin
    if (!nrst) begin
      div_r <= 16'h0000;
    end else if (ce) begin
      if (running) begin
        div_r <= div_nxt;
      end else begin
        div_r <= 16'h0000;
      end
    end
  end

  // Counter
  always @(posedge clk_sys) begin
    if (!nrst) begin
      count_r <= `DTW_COUNT_RESET;
    end else if (ce) begin
      if (load_wr) begin
        count_r <= load_value;
      end else if (restart) begin
        // Restart picks reload source by mode
        count_r <= (mode == `DTW_MODE_FREE) ? `DTW_FREE_RELOAD : load_value;
      end else if (expire) begin
        // Free-running ignores load on reload
        count_r <= (mode == `DTW_MODE_FREE) ? `DTW_FREE_RELOAD : load_value;
      end else if (running && tick && count_r == 16'h0000) begin
        // Reached zero by load or disable path: reload as after expiry
        count_r <= (mode == `DTW_MODE_FREE) ? `DTW_FREE_RELOAD : load_value;
      end else if (running && tick) begin
        // Resume from held value, no forced preset
        count_r <= count_r - 16'h0001;
      end
    end
  end
endmodule

// file: rtl/dtw_top.v
// Dual 16-bit timer block with watchdog, Wishbone slave
`timescale 1ns/1ns
`include "dtw_map.vh"
module dtw_top #(
  parameter WIDTH = 16
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Power-management watchdog alarm, asynchronous pin
  input wire pmu_wd_alarm,
  // Interrupts to processor
  output wire irq_timer0,
  output wire irq_timer1,
  // Chip reset request and pin
  output reg wd_chip_reset_r,
  output wire wd_pin_o,
  output wire wd_pin_oe
);
  // Bus request strobes
  wire req;
  wire wr;
  wire wr_lo;
  // Byte-lane qualified writes
  wire wr_b0;
  wire wr_b1;
  wire wr_b2;
  // Register state
  // Expiry flags, one per timer
  reg [1:0] flag_r;
  // Load values
  reg [WIDTH-1:0] load0_r;
  reg [WIDTH-1:0] load1_r;
  // Control words, bit 15 kept as plain storage
  reg [15:0] ctl0_r;
  reg [15:0] ctl1_r;
  // Watchdog reset seen, survives the pulse
  reg wd_occ_r;
  // Chip-select pin function
  reg [1:0] pinfn_r;
  // Cycles left in the chip reset pulse
  reg [1:0] pulse_cnt_r;
  // Alarm synchroniser stages
  reg pmu_s1_r;
  reg pmu_s2_r;
  // Channel results
  wire [WIDTH-1:0] cnt0;
  wire [WIDTH-1:0] cnt1;
  // Expiry and self-disable events, one cycle each
  wire exp0;
  wire exp1;
  wire clr0;
  wire clr1;
  // Effective modes
  wire [1:0] mode0_eff;
  wire [1:0] mode1;
  // Watchdog decision
  wire wd_alarm;
  wire wd_fire;
  // Write and restart strobes into the channels
  wire ld0_wr;
  wire ld1_wr;
  wire rst0;
  wire rst1;
  // Load value seen by each channel, new word bypassed in on its write cycle
  wire [WIDTH-1:0] load0_in;
  wire [WIDTH-1:0] load1_in;

  // Address match used in several decodes
  // Word match only; byte offsets inside a register alias the same word
  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr[7:2] == off[7:2]);
    end
  endfunction

  // Single-cycle answer: ack one cycle after request, dropped next cycle
  // Masking with ack keeps a held strobe from being taken twice;
  // the cost is one idle cycle between back-to-back requests
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign wr_lo = wr && wb_sel_i[0];
  assign wr_b0 = wr && wb_sel_i[0];
  assign wr_b1 = wr && wb_sel_i[1];
  assign wr_b2 = wr && wb_sel_i[2];

  // Load writes need both low lanes to form the 16-bit value
  // Partial-lane writes are dropped rather than merged into half a count
  assign ld0_wr = wr && (wb_sel_i[1:0] == 2'h3) && hit(wb_adr_i, `DTW_OFF_LOAD0);
  assign ld1_wr = wr && (wb_sel_i[1:0] == 2'h3) && hit(wb_adr_i, `DTW_OFF_LOAD1);
  // Counter copies the new word at the edge the register takes it;
  // reading the register here would hand the channel the previous value
  assign load0_in = ld0_wr ? wb_dat_i[WIDTH-1:0] : load0_r;
  assign load1_in = ld1_wr ? wb_dat_i[WIDTH-1:0] : load1_r;
  // Restart strobes, never stored
  assign rst0 = wr_lo && hit(wb_adr_i, `DTW_OFF_STAT) && wb_dat_i[`DTW_STAT_RST0];
  assign rst1 = wr_lo && hit(wb_adr_i, `DTW_OFF_STAT) && wb_dat_i[`DTW_STAT_RST1];

  // Timer 0 treats watchdog code as time-out
  // Keeps timer 0 away from the chip reset path altogether
  assign mode0_eff = (ctl0_r[5:4] == `DTW_MODE_WATCHDOG) ? `DTW_MODE_TIMEOUT
                                                       : ctl0_r[5:4];
  assign mode1 = ctl1_r[`DTW_CTL_MODE_HI:`DTW_CTL_MODE_LO];

  // Timer 0 channel
  dtw_channel #(.WIDTH(WIDTH), .PS_W(4)) u_ch0 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(ctl0_r[`DTW_CTL_EN]),
    .mode(mode0_eff),
    .prescale(ctl0_r[3:0]),
    .load_value(load0_in),
    .load_wr(ld0_wr),
    .restart(rst0),
    .count_r(cnt0),
    .expire(exp0),
    .clr_enable(clr0)
  );

  // Timer 1 channel, narrower pre-scale field
  // Bit 3 of timer 1 control is not stored, so its code tops out at 7
  dtw_channel #(.WIDTH(WIDTH), .PS_W(3)) u_ch1 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .enable(ctl1_r[`DTW_CTL_EN]),
    .mode(mode1),
    .prescale(ctl1_r[2:0]),
    .load_value(load1_in),
    .load_wr(ld1_wr),
    .restart(rst1),
    .count_r(cnt1),
    .expire(exp1),
    .clr_enable(clr1)
  );

  // Alarm pin passes two flops before use
  // Alarm comes from another clock domain; only the second flop is read,
  // so a metastable first stage never reaches the watchdog decision
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pmu_s1_r <= 1'b0;
      pmu_s2_r <= 1'b0;
    end else if (ce) begin
      pmu_s1_r <= pmu_wd_alarm;
      pmu_s2_r <= pmu_s1_r;
    end
  end

  // Watchdog alarm source select
  // Timer 1 reaches the chip reset only in watchdog mode;
  // its other modes just raise the expiry flag
  assign wd_alarm = ctl1_r[`DTW_CTL_WDSRC] ? pmu_s2_r
                                           : (exp1 && mode1 == `DTW_MODE_WATCHDOG);
  assign wd_fire = wd_alarm && !wd_chip_reset_r;

  // Interrupt lines follow sticky flags
  assign irq_timer0 = flag_r[`DTW_STAT_INT0];
  assign irq_timer1 = flag_r[`DTW_STAT_INT1];

  // Expiry flags: set beats clear
  // Losing an expiry to a racing clear would hide a whole period
  // Flags are left alone by the watchdog pulse; software clears them
  always @(posedge clk_sys) begin
    if (!nrst) begin
      flag_r <= 2'h0;
    end else if (ce) begin
      if (exp0) begin
        flag_r[0] <= 1'b1;
      end else if (wr_lo && hit(wb_adr_i, `DTW_OFF_STAT) && wb_dat_i[0]) begin
        flag_r[0] <= 1'b0;
      end
      if (exp1) begin
        flag_r[1] <= 1'b1;
      end else if (wr_lo && hit(wb_adr_i, `DTW_OFF_STAT) && wb_dat_i[1]) begin
        flag_r[1] <= 1'b0;
      end
    end
  end

  // Load and control registers; watchdog expiry resets them
  // Held in reset for the whole pulse, so a late bus write cannot
  // re-arm the watchdog before the chip reset logic has acted
  always @(posedge clk_sys) begin
    if (!nrst || wd_chip_reset_r) begin
      load0_r <= `DTW_LOAD_RESET;
      load1_r <= `DTW_LOAD_RESET;
      ctl0_r <= 16'h0000;
      ctl1_r <= 16'h0000;
    end else if (ce) begin
      // Load value rewritable any time outside the chip reset pulse
      if (ld0_wr) begin
        load0_r <= wb_dat_i[15:0];
      end
      if (ld1_wr) begin
        load1_r <= wb_dat_i[15:0];
      end
      // Control 0: byte lanes
      if (wr_b0 && hit(wb_adr_i, `DTW_OFF_CTL0)) begin
        ctl0_r[7:0] <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      end else if (clr0) begin
        ctl0_r[`DTW_CTL_EN] <= 1'b0;
      end
      if (wr_b1 && hit(wb_adr_i, `DTW_OFF_CTL0)) begin
        ctl0_r[15] <= wb_dat_i[15];
      end
      // Control 1
      if (wr_b0 && hit(wb_adr_i, `DTW_OFF_CTL1)) begin
        ctl1_r[7:0] <= {wb_dat_i[7:4], 1'b0, wb_dat_i[2:0]};
      end else if (clr1) begin
        ctl1_r[`DTW_CTL_EN] <= 1'b0;
      end
      if (wr_b1 && hit(wb_adr_i, `DTW_OFF_CTL1)) begin
        ctl1_r[15] <= wb_dat_i[15];
      end
    end
  end

  // Chip-select pin function, kept through the pulse it shapes
  // Clearing it at the first pulse edge would release the pin after one
  // clock; the watchdog reset lands on it in the pulse's last cycle instead
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pinfn_r <= `DTW_PINFN_RESET;
    end else if (ce) begin
      if (wd_chip_reset_r && (pulse_cnt_r == 2'h0)) begin
        // Last pulse cycle: watchdog reset reaches the pin function
        pinfn_r <= `DTW_PINFN_RESET;
      end else if (wr_b2 && hit(wb_adr_i, `DTW_OFF_PINFN)) begin
        // Only lane 2 carries the field
        pinfn_r <= wb_dat_i[22:21];
      end
    end
  end

  // Reset-cause flag survives watchdog reset; set wins over clear
  // Only the reset input or a write of 1 to bit 1 clears it, so firmware still sees it
  // after the chip reset logic has restarted the processor
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wd_occ_r <= 1'b0;
    end else if (ce) begin
      if (wd_fire) begin
        wd_occ_r <= 1'b1;
      end else if (wr_lo && hit(wb_adr_i, `DTW_OFF_RSTCAUSE) && wb_dat_i[1]) begin
        wd_occ_r <= 1'b0;
      end
    end
  end

  // Chip reset pulse, three clocks long
  // Counter holds the cycles left after the first; the fire term is masked
  // while the pulse runs, so one expiry never stretches into two pulses
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wd_chip_reset_r <= 1'b0;
      pulse_cnt_r <= 2'h0;
    end else if (ce) begin
      if (wd_fire) begin
        wd_chip_reset_r <= 1'b1;
        pulse_cnt_r <= `DTW_WDPULSE_CYC - 2'h1;
      end else if (pulse_cnt_r != 2'h0) begin
        pulse_cnt_r <= pulse_cnt_r - 2'h1;
      end else begin
        wd_chip_reset_r <= 1'b0;
      end
    end
  end

  // Pin low during pulse when configured, high between pulses; released when not configured
  // Output enable follows the pin function alone; outside a pulse
  // the driven level is high, the idle state of the line
  assign wd_pin_o = !wd_chip_reset_r;
  assign wd_pin_oe = (pinfn_r == `DTW_PINFN_WDOUT);

  // Read mux and ack
  // Data is zero outside a read answer, so a stray sample reads nothing
  // Restart bits have no storage and always read back zero
  // Unmapped words answer too, so a wrong address never hangs the bus
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce) begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        case (wb_adr_i[7:2])
          6'h00: wb_dat_o <= {30'h00000000, flag_r};
          6'h04: wb_dat_o <= {16'h0000, load0_r};
          6'h05: wb_dat_o <= {16'h0000, cnt0};
          6'h06: wb_dat_o <= {16'h0000, ctl0_r};
          6'h08: wb_dat_o <= {16'h0000, load1_r};
          6'h09: wb_dat_o <= {16'h0000, cnt1};
          6'h0A: wb_dat_o <= {16'h0000, ctl1_r};
          6'h0C: wb_dat_o <= {30'h00000000, wd_occ_r, 1'b0};
          6'h0D: wb_dat_o <= {9'h000, pinfn_r, 21'h000000};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// file: dv/dtw_checker_properties.sv
// Port-level assertions for the dual timer block
`timescale 1ns/1ns
module dtw_checker (
  // Clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Events
  input wire irq_timer0,
  input wire irq_timer1,
  input wire wd_chip_reset_r,
  input wire wd_pin_o,
  input wire wd_pin_oe
);
  // Request taken at this edge
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  // Status write taken at this edge
  wire wst = req && wb_we_i && wb_adr_i == 8'h00;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_ack_lat; req |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one; wb_ack_o && ce |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_stat_rd; wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[31:2] == 30'h0;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("restart bits read");
  property p_val_rd; wb_ack_o && !wb_we_i && wb_adr_i[7:4] != 4'h3 && wb_adr_i[3:0] == 4'h4
    |-> wb_dat_o[31:16] == 16'h0; endproperty
  a_val_rd: assert property (p_val_rd) else $error("count upper bits");
  property p_clr0; $fell(irq_timer0) |-> $past(wst && wb_dat_i[0]); endproperty
  a_clr0: assert property (p_clr0) else $error("irq0 fell unasked");
  property p_clr1; $fell(irq_timer1) |-> $past(wst && wb_dat_i[1]); endproperty
  a_clr1: assert property (p_clr1) else $error("irq1 fell unasked");
  property p_wd_len; $rose(wd_chip_reset_r) |-> wd_chip_reset_r[*3] ##1 !wd_chip_reset_r;
  endproperty
  a_wd_len: assert property (p_wd_len) else $error("reset pulse length");
  property p_pin; wd_pin_o == !wd_chip_reset_r; endproperty
  a_pin: assert property (p_pin) else $error("pin level");
  property p_pin_hold; $rose(wd_chip_reset_r) && wd_pin_oe |-> (wd_pin_oe && !wd_pin_o)[*3];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin pulse cut short");
endmodule
bind dtw_top dtw_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_timer0(irq_timer0), .irq_timer1(irq_timer1),
  .wd_chip_reset_r(wd_chip_reset_r), .wd_pin_o(wd_pin_o), .wd_pin_oe(wd_pin_oe));

// file: dv/dtw_cpu_model.sv
// Processor interrupt inputs and chip reset logic
`timescale 1ns/1ns
module dtw_cpu_model (
  // Clock
  input wire clk_sys,
  // Requests from the timer block
  input wire irq_timer0,
  input wire irq_timer1,
  input wire wd_chip_reset_r,
  // Shared chip-select pin
  input wire wd_pin_o,
  input wire wd_pin_oe,
  output wire pin_level,
  output int wd_events
);
  // Previous reset level for edge detection
  logic prev_r = 1'h0;
  // Pull-up holds the pin high when undriven
  assign pin_level = wd_pin_oe ? wd_pin_o : 1'h1;
  initial wd_events = 0;
  // One chip reset per leading edge
  always @(posedge clk_sys) begin
    prev_r <= wd_chip_reset_r;
    if (wd_chip_reset_r === 1'h1 && prev_r !== 1'h1)
      wd_events <= wd_events + 1;
  end
endmodule

// file: dv/dtw_top_tb.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ns
module dtw_top_tb;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} dtw_row_t;
  // Drive side
  logic clk_sys, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, pmu_wd_alarm;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, rd, held;
  // Observed side
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq_timer0, irq_timer1, wd_chip_reset_r, wd_pin_o, wd_pin_oe, pin_level;
  int n_fail, samples_checked, wd_events;
  // Reset values, unmapped place, load copy, read-only count
  dtw_row_t rows [12] = '{'{1'h0, 8'h00, 32'h0, 32'h0}, '{1'h0, 8'h10, 32'h0, 32'h0},
    '{1'h0, 8'h14, 32'h0, 32'hFFFF}, '{1'h0, 8'h24, 32'h0, 32'hFFFF},
    '{1'h0, 8'h18, 32'h0, 32'h0}, '{1'h0, 8'h34, 32'h0, 32'h400000},
    '{1'h1, 8'h3C, 32'hFFFF, 32'h0}, '{1'h0, 8'h3C, 32'h0, 32'h0},
    '{1'h1, 8'h10, 32'h1234, 32'h0}, '{1'h0, 8'h14, 32'h0, 32'h1234},
    '{1'h1, 8'h14, 32'h0, 32'h0}, '{1'h0, 8'h14, 32'h0, 32'h1234}};
  dtw_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pmu_wd_alarm(pmu_wd_alarm),
    .irq_timer0(irq_timer0), .irq_timer1(irq_timer1), .wd_chip_reset_r(wd_chip_reset_r),
    .wd_pin_o(wd_pin_o), .wd_pin_oe(wd_pin_oe));
  dtw_cpu_model cpu_u (.clk_sys(clk_sys), .irq_timer0(irq_timer0), .irq_timer1(irq_timer1),
    .wd_chip_reset_r(wd_chip_reset_r), .wd_pin_o(wd_pin_o), .wd_pin_oe(wd_pin_oe),
    .pin_level(pin_level), .wd_events(wd_events));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    chk("ack", n < 20, 1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  // Bounded wait on irq0 or chip reset
  task automatic wait_on(input int s, input int lim);
    int n;
    n = 0;
    while ((s == 0 ? irq_timer0 : wd_chip_reset_r) !== 1'h1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk("event wait", n < lim, 1);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Whole run needs well under this
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, pmu_wd_alarm} = 5'h0;
    {ce, wb_sel_i, wb_adr_i, wb_dat_i} = {1'h1, 4'hF, 40'h0};
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we) chk($sformatf("row %0d", i), rd, rows[i].e);
    end
    // Time-out codes 2 and 3 on the first timer
    for (int m = 2; m < 4; m++) begin
      wb(1'h1, 8'h10, 32'h4);
      wb(1'h1, 8'h18, 32'h80 | (m << 4));
      wait_on(0, 50);
      rdchk("ctl0 after expiry", 8'h18, m << 4);
      rdchk("val0 after expiry", 8'h14, 32'h4);
      wb(1'h1, 8'h00, 32'h0);
      chk("irq0 kept", irq_timer0, 1);
      wb(1'h1, 8'h00, 32'h1);
      chk("irq0 cleared", irq_timer0, 0);
    end
    chk("no reset from t0", wd_events, 0);
    // Periodic, divide by 16
    wb(1'h1, 8'h18, 32'h93);
    wait_on(0, 300);
    rdchk("ctl0 periodic", 8'h18, 32'h93);
    wb(1'h1, 8'h18, 32'h13);
    wb(1'h0, 8'h14, 32'h0);
    held = rd;
    chk("val0 range", held >= 1 && held <= 4, 1);
    rdchk("val0 held", 8'h14, held);
    wb(1'h1, 8'h00, 32'h1);
    // Zero load stops counting, seen from an all-ones count
    wb(1'h1, 8'h18, 32'h0);
    wb(1'h1, 8'h10, 32'h0);
    wb(1'h1, 8'h00, 32'h10);
    wb(1'h1, 8'h18, 32'h90);
    repeat (20) @(posedge clk_sys);
    rdchk("val0 zero load", 8'h14, 32'hFFFF);
    chk("irq0 idle", irq_timer0, 0);
    // Free-running
    wb(1'h1, 8'h18, 32'h0);
    wb(1'h1, 8'h10, 32'h3);
    rdchk("val0 free load", 8'h14, 32'h3);
    wb(1'h1, 8'h18, 32'h80);
    wait_on(0, 50);
    wb(1'h1, 8'h18, 32'h0);
    wb(1'h0, 8'h14, 32'h0);
    chk("val0 free reload", rd[31:8], 32'hFF);
    wb(1'h1, 8'h10, 32'h5);
    wb(1'h1, 8'h00, 32'h11);
    rdchk("restart free", 8'h14, 32'hFFFF);
    wb(1'h1, 8'h18, 32'h10);
    wb(1'h1, 8'h00, 32'h10);
    rdchk("restart load", 8'h14, 32'h5);
    // Watchdog on the second timer, kicked then left to expire
    wb(1'h1, 8'h34, 32'h200000);
    chk("pin enabled", wd_pin_oe, 1);
    wb(1'h1, 8'h20, 32'h20);
    wb(1'h1, 8'h28, 32'hB0);
    for (int k = 0; k < 4; k++) wb(1'h1, 8'h20, 32'h20);
    chk("kicked", wd_events, 0);
    wb(1'h1, 8'h20, 32'h6);
    wait_on(1, 50);
    chk("pin low", pin_level, 0);
    rdchk("reset cause", 8'h30, 32'h2);
    rdchk("ctl1 cleared", 8'h28, 32'h0);
    chk("one reset", wd_events, 1);
    wb(1'h1, 8'h30, 32'h2);
    rdchk("cause cleared", 8'h30, 32'h0);
    wb(1'h1, 8'h00, 32'h2);
    chk("irq1 cleared", irq_timer1, 0);
    rdchk("pin function reset", 8'h34, 32'h400000);
    // Alarm from the power watchdog through the synchroniser
    wb(1'h1, 8'h28, 32'h40);
    pmu_wd_alarm <= 1'h1;
    wait_on(1, 50);
    pmu_wd_alarm <= 1'h0;
    rdchk("pmu cause", 8'h30, 32'h2);
    chk("two resets", wd_events, 2);
    // Reset again in mid-run
    nrst <= 1'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    rdchk("cause after reset", 8'h30, 32'h0);
    rdchk("val1 after reset", 8'h24, 32'hFFFF);
    finish_test;
  end
endmodule
